// file: logic/smart_identify_regs.vh
// Constants for the identify and health-monitoring responder
`ifndef SMART_IDENTIFY_REGS_VH
`define SMART_IDENTIFY_REGS_VH
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_FEATURES    12'h008
`define OFF_COMMAND     12'h00C
`define OFF_CYL         12'h010
`define OFF_SPARE       12'h014
`define OFF_ERASE_AVG   12'h018
`define OFF_SPARE_THR   12'h01C
`define OFF_COLL        12'h020
`define OFF_CAP         12'h024
`define OFF_DATA        12'h028
`define OFF_SCT         12'h02C
`define OFF_POWER_LOSS  12'h030
`define OFF_HOST_READ   12'h034
`define CMD_HEALTH      8'hB0
`define CMD_IDENTIFY    8'hEC
`define CMD_SET_FEAT    8'hEF
`define SUB_READ_DATA   8'hD0
`define SUB_READ_THR    8'hD1
`define SUB_AUTOSAVE    8'hD2
`define SUB_SAVE_ATTR   8'hD3
`define SUB_OFFLINE     8'hD4
`define SUB_READ_LOG    8'hD5
`define SUB_WRITE_LOG   8'hD6
`define SUB_ENABLE      8'hD8
`define SUB_DISABLE     8'hD9
`define SUB_STATUS      8'hDA
`define SF_WC_ON        8'h02
`define SF_WC_OFF       8'h82
`define SF_REVERT_OFF   8'h66
`define SF_REVERT_ON    8'hCC
`define SCT_ERC         16'h0003
`define SCT_FEAT        16'h0004
`define SCT_TABLES      16'h0005
`define CYL_OK          16'hC24F
`define CYL_BAD         16'h2CF4
`define ID_W47          16'h8001
`define ID_W80          16'h03F0
`define ID_W88          16'h007F
`define ID_W105         16'h0100
`define ID_W106         16'h5000
`define ID_W222         16'h107F
`define ID_SIG          8'hA5
`define HOST_READ_SHIFT 16
`define ATTR_POWER_LOSS 8'hAE
`define ATTR_HOST_READ  8'hF2
`define ATTR_CRC        8'hC7
`define ATTR_ERASE_FAIL 8'hAC
`define ATTR_PROG_FAIL  8'hB5
`define ATTR_READ_ERR   8'h01
`define HB_COLL_STAT    9'd362
`define HB_TEST_STAT    9'd363
`define HB_COLL_T0      9'd364
`define HB_COLL_T1      9'd365
`define HB_SPARE0       9'd418
`define HB_ERASE0       9'd420
`define HB_ATTR_FIRST   9'd2
`define HB_ATTR_LAST    9'd361
`define HB_CHECKSUM     9'd511
`define ATTR_SLOT       6'd12
`endif

// file: logic/image_rom.v
// Identify word and health byte generator
`timescale 1ns/1ps
`default_nettype none
`include "smart_identify_regs.vh"
module image_rom #(
    parameter [127:0] SERIAL = 128'h4130_3030_3030_3030_3031_2020_2020_2020,
    parameter [63:0] FW_REV = 64'h5245_5631_2020_2020,
    parameter [127:0] MODEL = 128'h534F_4C49_4420_5354_4154_4520_4D4F_4420
) (
    input wire [7:0] word_idx,
    input wire [31:0] capacity,
    output reg [15:0] id_word,
    input wire [8:0] byte_idx,
    input wire [7:0] coll_stat,
    input wire [7:0] test_stat,
    input wire [15:0] coll_time,
    input wire [15:0] spare,
    input wire [31:0] erase_avg,
    input wire [31:0] power_loss,
    input wire [31:0] host_read_units,
    input wire [31:0] crc_errs,
    output reg [7:0] hb_byte
);
    wire [8:0] rel = byte_idx - `HB_ATTR_FIRST;
    // Twelve-byte slots; dividing by a constant keeps the slot walk free of extra counters
    wire [8:0] slot_num = rel / {3'h0, `ATTR_SLOT};
    wire [8:0] slot_byte = rel - slot_num * {3'h0, `ATTR_SLOT};
    reg [7:0] attr_id;
    reg [31:0] attr_raw;
    always @* begin
        id_word = 16'h0000;
        case (word_idx)
            8'd7: id_word = capacity[31:16];
            8'd8: id_word = capacity[15:0];
            8'd47: id_word = `ID_W47;
            8'd57: id_word = capacity[15:0];
            8'd58: id_word = capacity[31:16];
            8'd80: id_word = `ID_W80;
            8'd88: id_word = `ID_W88;
            8'd105: id_word = `ID_W105;
            8'd106: id_word = `ID_W106;
            8'd222: id_word = `ID_W222;
            8'd255: id_word = {8'h00, `ID_SIG};
            default: begin
                // Big-endian bytes per word, left justified
                if (word_idx >= 8'd10 && word_idx <= 8'd17)
                    id_word = SERIAL[127 - 16 * (word_idx - 8'd10) -: 16];
                else if (word_idx >= 8'd18 && word_idx <= 8'd19)
                    id_word = 16'h2020;
                else if (word_idx >= 8'd23 && word_idx <= 8'd26)
                    id_word = FW_REV[63 - 16 * (word_idx - 8'd23) -: 16];
                else if (word_idx >= 8'd27 && word_idx <= 8'd34)
                    id_word = MODEL[127 - 16 * (word_idx - 8'd27) -: 16];
                else if (word_idx >= 8'd35 && word_idx <= 8'd41)
                    id_word = 16'h2020;
            end
        endcase
    end
    // Attribute slots of twelve bytes: id, raw LSB first, zero pad
    always @* begin
        attr_id = 8'h00;
        attr_raw = 32'h0000_0000;
        case (slot_num)
            9'd0: begin attr_id = `ATTR_READ_ERR; attr_raw = 32'h0000_0000; end
            9'd1: begin attr_id = `ATTR_ERASE_FAIL; attr_raw = 32'h0000_0000; end
            9'd2: begin attr_id = `ATTR_POWER_LOSS; attr_raw = power_loss; end
            9'd3: begin attr_id = `ATTR_PROG_FAIL; attr_raw = 32'h0000_0000; end
            9'd4: begin attr_id = `ATTR_CRC; attr_raw = crc_errs; end
            9'd5: begin attr_id = `ATTR_HOST_READ; attr_raw = host_read_units; end
            default: begin attr_id = 8'h00; attr_raw = 32'h0000_0000; end
        endcase
    end
    always @* begin
        hb_byte = 8'h00;
        if (byte_idx >= `HB_ATTR_FIRST && byte_idx <= `HB_ATTR_LAST) begin
            case (slot_byte)
                9'd0: hb_byte = attr_id;
                9'd1: hb_byte = attr_raw[7:0];
                9'd2: hb_byte = attr_raw[15:8];
                9'd3: hb_byte = attr_raw[23:16];
                9'd4: hb_byte = attr_raw[31:24];
                default: hb_byte = 8'h00;
            endcase
        end else begin
            case (byte_idx)
                `HB_COLL_STAT: hb_byte = coll_stat;
                `HB_TEST_STAT: hb_byte = test_stat;
                `HB_COLL_T0: hb_byte = coll_time[7:0];
                `HB_COLL_T1: hb_byte = coll_time[15:8];
                `HB_SPARE0: hb_byte = spare[7:0];
                `HB_SPARE0 + 9'd1: hb_byte = spare[15:8];
                `HB_ERASE0: hb_byte = erase_avg[7:0];
                `HB_ERASE0 + 9'd1: hb_byte = erase_avg[15:8];
                `HB_ERASE0 + 9'd2: hb_byte = erase_avg[23:16];
                `HB_ERASE0 + 9'd3: hb_byte = erase_avg[31:24];
                default: hb_byte = 8'h00;
            endcase
        end
    end
endmodule // image_rom
`default_nettype wire

// file: logic/smart_identify_responder.v
// APB-controlled identify and health-monitoring command responder
// Behaviour
// - Decode subcommands D0h through DAh as listed.
// - Return status reports spare-below-threshold through the cylinder register.
// - Read data returns one 512-byte health structure as data-in.
// - Collection status at 362, self-test status 363, collection time 364-365.
// - Spare block count at 418-419, average erase count at 420-423.
// - Reserved health bytes read as zero.
// - Fixed health bytes hold constants independent of state.
// - Bytes 2-361 hold attribute entries: id, raw value LSB first, zero pad.
// - Attributes include AEh power losses plus erase, program, read, CRC counters.
// - Attribute F2h counts host bytes read in 32 MB units.
// - Transport extension accepts action codes 0003h, 0004h, 0005h.
// - Set features 02h/82h write cache, 66h/CCh power-on revert.
// - Identify word 47 reads 8001h.
// - Sector count in words 7-8, MSW in word 7.
// - Capacity in words 57-58, LSW in word 57.
// - Serial, firmware, model are left-justified big-endian ASCII.
// - Word 106 sets bits 12 and 14, clears bit 15.
// - Word 105 reads 0100h.
// - Word 88 reads 007Fh.
// - Word 222 reads 107Fh.
// - Word 80 reads 03F0h.
// - Health subcommands share opcode B0h.
`timescale 1ns/1ps
`default_nettype none
`include "smart_identify_regs.vh"
module smart_identify_responder #(
    parameter [31:0] CAPACITY_DEF = 32'h0000_0000,
    parameter [15:0] SPARE_THR_DEF = 16'h0010
) (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg wcache_en_q,
    output reg revert_en_q
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ID = 2'd1;
    localparam [1:0] ST_HB = 2'd2;

    reg [1:0] state_q;
    reg [8:0] idx_q;
    reg [7:0] features_q;
    reg [7:0] sum_q;
    reg [15:0] idsum_q;
    reg [15:0] cyl_q;
    reg [15:0] spare_q;
    reg [15:0] spare_thr_q;
    reg [31:0] erase_avg_q;
    reg [31:0] capacity_q;
    reg [31:0] power_loss_q;
    reg [31:0] host_read_q;
    reg [31:0] crc_q;
    reg [23:0] coll_q;
    reg [7:0] test_stat_q;
    reg [15:0] sct_q;
    reg health_en_q;
    reg autosave_q;
    reg abort_q;
    reg [15:0] data_q;
    reg data_valid_q;
    reg [15:0] id_word;
    reg [7:0] hb_byte;
    wire [15:0] id_word_w;
    wire [7:0] hb_byte_w;

    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    image_rom u_rom (
        .word_idx(idx_q[7:0]),
        .capacity(capacity_q),
        .id_word(id_word_w),
        .byte_idx(idx_q),
        .coll_stat(coll_q[7:0]),
        .test_stat(test_stat_q),
        .coll_time(coll_q[23:8]),
        .spare(spare_q),
        .erase_avg(erase_avg_q),
        .power_loss(power_loss_q),
        .host_read_units(host_read_q),
        .crc_errs(crc_q),
        .hb_byte(hb_byte_w)
    );

    always @* begin
        id_word = id_word_w;
        hb_byte = hb_byte_w;
        if (idx_q[7:0] == 8'hFF)
            id_word = {(8'h00 - idsum_q[7:0] - `ID_SIG), `ID_SIG};
        if (idx_q == `HB_CHECKSUM)
            hb_byte = 8'h00 - sum_q;
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            idx_q <= 9'd0;
            features_q <= 8'h00;
            sum_q <= 8'h00;
            idsum_q <= 16'h0000;
            cyl_q <= 16'h0000;
            spare_q <= 16'h0000;
            spare_thr_q <= SPARE_THR_DEF;
            erase_avg_q <= 32'h0000_0000;
            capacity_q <= CAPACITY_DEF;
            power_loss_q <= 32'h0000_0000;
            host_read_q <= 32'h0000_0000;
            crc_q <= 32'h0000_0000;
            coll_q <= 24'h000000;
            test_stat_q <= 8'h00;
            sct_q <= 16'h0000;
            health_en_q <= 1'b1;
            autosave_q <= 1'b0;
            abort_q <= 1'b0;
            data_q <= 16'h0000;
            data_valid_q <= 1'b0;
            wcache_en_q <= 1'b1;
            revert_en_q <= 1'b1;
        end else begin
            // Data staged one identify word or one health byte at a time; reading DATA pops the next one
            if (state_q == ST_ID && !data_valid_q) begin
                data_q <= id_word;
                data_valid_q <= 1'b1;
                idsum_q <= idsum_q + {8'h00, id_word[15:8]} + {8'h00, id_word[7:0]};
            end else if (state_q == ST_HB && !data_valid_q) begin
                data_q <= {8'h00, hb_byte};
                data_valid_q <= 1'b1;
                sum_q <= sum_q + hb_byte;
            end
            if (rd && paddr == `OFF_DATA && data_valid_q) begin
                data_valid_q <= 1'b0;
                if ((state_q == ST_ID && idx_q[7:0] == 8'hFF) || (state_q == ST_HB && idx_q == `HB_CHECKSUM))
                    state_q <= ST_IDLE;
                else
                    idx_q <= idx_q + 9'd1;
            end
            if (wr) begin
                case (paddr)
                    `OFF_FEATURES: features_q <= pwdata[7:0];
                    `OFF_SPARE: spare_q <= pwdata[15:0];
                    `OFF_ERASE_AVG: erase_avg_q <= pwdata;
                    `OFF_SPARE_THR: spare_thr_q <= pwdata[15:0];
                    `OFF_COLL: begin
                        coll_q <= pwdata[23:0];
                        test_stat_q <= pwdata[31:24];
                    end
                    `OFF_CAP: capacity_q <= pwdata;
                    `OFF_POWER_LOSS: power_loss_q <= pwdata;
                    `OFF_HOST_READ: host_read_q <= pwdata >> `HOST_READ_SHIFT;
                    `OFF_CTRL: crc_q <= pwdata;
                    `OFF_SCT: begin
                        abort_q <= !(pwdata[15:0] == `SCT_ERC || pwdata[15:0] == `SCT_FEAT ||
                            pwdata[15:0] == `SCT_TABLES);
                        sct_q <= pwdata[15:0];
                    end
                    `OFF_COMMAND: begin
                        abort_q <= 1'b0;
                        // A new command drops any transfer left pending, so stale data never streams
                        state_q <= ST_IDLE;
                        idx_q <= 9'd0;
                        data_valid_q <= 1'b0;
                        sum_q <= 8'h00;
                        idsum_q <= 16'h0000;
                        case (pwdata[7:0])
                            `CMD_IDENTIFY: state_q <= ST_ID;
                            `CMD_SET_FEAT: begin
                                case (features_q)
                                    `SF_WC_ON: wcache_en_q <= 1'b1;
                                    `SF_WC_OFF: wcache_en_q <= 1'b0;
                                    `SF_REVERT_OFF: revert_en_q <= 1'b0;
                                    `SF_REVERT_ON: revert_en_q <= 1'b1;
                                    default: abort_q <= 1'b1;
                                endcase
                            end
                            `CMD_HEALTH: begin
                                case (features_q)
                                    `SUB_READ_DATA: state_q <= ST_HB;
                                    `SUB_READ_THR: state_q <= ST_HB;
                                    `SUB_AUTOSAVE: autosave_q <= 1'b1;
                                    `SUB_SAVE_ATTR: autosave_q <= autosave_q;
                                    `SUB_OFFLINE: test_stat_q <= 8'h00;
                                    `SUB_READ_LOG: state_q <= ST_HB;
                                    `SUB_WRITE_LOG: abort_q <= 1'b0;
                                    `SUB_ENABLE: health_en_q <= 1'b1;
                                    `SUB_DISABLE: health_en_q <= 1'b0;
                                    `SUB_STATUS: cyl_q <= (spare_q < spare_thr_q) ? `CYL_BAD : `CYL_OK;
                                    default: abort_q <= 1'b1;
                                endcase
                            end
                            default: abort_q <= 1'b1;
                        endcase
                    end
                    default: abort_q <= abort_q;
                endcase
            end
        end
    end

    always @* begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                `OFF_STATUS: prdata = {26'h0, autosave_q, health_en_q, revert_en_q, wcache_en_q, abort_q,
                    data_valid_q};
                `OFF_FEATURES: prdata = {24'h0, features_q};
                `OFF_CYL: prdata = {16'h0, cyl_q};
                `OFF_SPARE: prdata = {16'h0, spare_q};
                `OFF_ERASE_AVG: prdata = erase_avg_q;
                `OFF_SPARE_THR: prdata = {16'h0, spare_thr_q};
                `OFF_COLL: prdata = {test_stat_q, coll_q};
                `OFF_CAP: prdata = capacity_q;
                `OFF_DATA: prdata = {15'h0, data_valid_q, data_q};
                `OFF_SCT: prdata = {16'h0, sct_q};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // smart_identify_responder
`default_nettype wire

// file: verification/host_model.sv
// Host-side APB master model that issues task-file commands to the responder
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [11:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // Request held until pready is seen high; data taken at that edge only
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Features go first: the device picks the operation from them at opcode time
    task automatic issue(input logic [7:0] feat, input logic [7:0] op);
        logic [31:0] r;
        xfer(1'b1, 12'h008, {24'h00_0000, feat}, r);
        xfer(1'b1, 12'h00C, {24'h00_0000, op}, r);
    endtask
endmodule // host_model
`default_nettype wire

// file: verification/responder_sva.sv
// Port-level checker for the identify and health responder
`timescale 1ns/1ps
`default_nettype none
module responder_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wcache_en_q,
    input wire logic revert_en_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic rd_acc;
    logic sf_cmd;
    assign rd_acc = psel & penable & ~pwrite;
    assign sf_cmd = psel & penable & pwrite & (paddr == 12'h00C) & (pwdata[7:0] == 8'hEF);
    a_ready_high: assert property (psel && penable |-> pready) else $error("pready low in access");
    a_no_slverr: assert property (psel && penable |-> !pslverr) else $error("pslverr raised");
    a_reset_vals: assert property ($rose(rstn) |-> wcache_en_q && revert_en_q) else $error("bad reset value");
    a_wcache_cause: assert property ($changed(wcache_en_q) |-> $past(sf_cmd)) else $error("cache flag moved");
    a_revert_cause: assert property ($changed(revert_en_q) |-> $past(sf_cmd)) else $error("revert flag moved");
    a_unmapped_zero: assert property (rd_acc && paddr >= 12'h038 |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_data_upper: assert property (rd_acc && paddr == 12'h028 |-> prdata[31:17] == 15'h0000)
        else $error("data upper bits set");
    a_status_mirror: assert property (rd_acc && paddr == 12'h004 |-> prdata[3:2] == {revert_en_q, wcache_en_q})
        else $error("status flags differ");
    a_cyl_code: assert property (rd_acc && paddr == 12'h010 && prdata[15:0] != 16'h0000
        |-> prdata[15:0] == 16'hC24F || prdata[15:0] == 16'h2CF4) else $error("bad cylinder code");
endmodule // responder_sva
bind smart_identify_responder responder_sva u_sva (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wcache_en_q(wcache_en_q), .revert_en_q(revert_en_q));
`default_nettype wire

// file: verification/smart_identify_responder_bench.sv
// Self-checking bench for the identify and health responder
`timescale 1ns/1ps
`default_nettype none
module smart_identify_responder_bench;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, wcache_en_q, revert_en_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] hb [0:511];
    logic [7:0] hb0 [0:511];
    int miscompares = 0;
    int samples_checked = 0;
    smart_identify_responder #(.CAPACITY_DEF(32'h0000_0000), .SPARE_THR_DEF(16'h0010)) uut (.ref_clk(ref_clk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wcache_en_q(wcache_en_q), .revert_en_q(revert_en_q));
    host_model u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready));
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic [7:0] e, input logic [7:0] g);
        chk(nm, {24'h00_0000, e}, {24'h00_0000, g});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        u_host.xfer(1'b0, a, 32'h0000_0000, r);
    endtask
    // Polls the data port; a unit counts only when the valid bit is up
    task automatic pop(output logic [15:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int n = 0; n < 8 && r[16] !== 1'b1; n++) rd(12'h028, r);
        chk("data_valid", 32'h1, {31'h0, r[16]});
        v = r[15:0];
    endtask
    task automatic t_identify();
        logic [15:0] w [0:255];
        logic [7:0] s;
        wr(12'h024, 32'h0012_3456);
        u_host.issue(8'h00, 8'hEC);
        s = 8'h00;
        for (int i = 0; i < 256; i++) begin
            pop(w[i]);
            s = s + w[i][7:0] + w[i][15:8];
        end
        chk("w7", 32'h0012, {16'h0000, w[7]});
        chk("w8", 32'h3456, {16'h0000, w[8]});
        chk("w10", 32'h4130, {16'h0000, w[10]});
        chk("w23", 32'h5245, {16'h0000, w[23]});
        chk("w27", 32'h534F, {16'h0000, w[27]});
        chk("w47", 32'h8001, {16'h0000, w[47]});
        chk("w57", 32'h3456, {16'h0000, w[57]});
        chk("w58", 32'h0012, {16'h0000, w[58]});
        chk("w80", 32'h03F0, {16'h0000, w[80]});
        chk("w88", 32'h007F, {16'h0000, w[88]});
        chk("w105", 32'h0100, {16'h0000, w[105]});
        chk("w106", 32'h3, {29'h0, w[106][15], w[106][14], w[106][12]});
        chk("w222", 32'h107F, {16'h0000, w[222]});
        chkb("w255", 8'hA5, w[255][7:0]);
        chkb("id_sum", 8'h00, s);
    endtask
    task automatic health_read(output logic [7:0] s);
        logic [15:0] v;
        s = 8'h00;
        u_host.issue(8'hD0, 8'hB0);
        for (int i = 0; i < 512; i++) begin
            pop(v);
            hb[i] = v[7:0];
            s = s + v[7:0];
        end
    endtask
    task automatic t_health();
        logic [7:0] s;
        logic [7:0] ids [6] = '{8'h01, 8'hAC, 8'hAE, 8'hB5, 8'hC7, 8'hF2};
        wr(12'h014, 32'h0000_0123);
        wr(12'h018, 32'h89AB_CDEF);
        wr(12'h020, 32'h5A12_3407);
        wr(12'h030, 32'h0000_0055);
        wr(12'h034, 32'h0003_0000);
        health_read(s);
        chkb("hb_sum", 8'h00, s);
        chk("hb362", 32'h5A12_3407, {hb[363], hb[365], hb[364], hb[362]});
        chk("hb418", 32'h0123, {16'h0000, hb[419], hb[418]});
        chk("hb420", 32'h89AB_CDEF, {hb[423], hb[422], hb[421], hb[420]});
        for (int i = 375; i < 386; i++) chkb("reserved", 8'h00, hb[i]);
        for (int k = 0; k < 6; k++) chkb("attr_id", ids[k], hb[2 + 12 * k]);
        chk("loss_raw", 32'h55, {24'h00_0000, hb[27]});
        chk("read_raw", 32'h3, {16'h0000, hb[64], hb[63]});
        hb0 = hb;
        wr(12'h014, 32'h0000_0456);
        health_read(s);
        chkb("hb_sum2", 8'h00, s);
        chk("hb418b", 32'h0456, {16'h0000, hb[419], hb[418]});
        for (int i = 367; i < 375; i++) chkb("fixed", hb0[i], hb[i]);
    endtask
    task automatic t_status();
        logic [31:0] r;
        wr(12'h014, 32'h0000_0010);
        u_host.issue(8'hDA, 8'hB0);
        rd(12'h010, r);
        chk("cyl_ok", 32'hC24F, {16'h0000, r[15:0]});
        wr(12'h014, 32'h0000_000F);
        u_host.issue(8'hDA, 8'hB0);
        rd(12'h010, r);
        chk("cyl_low", 32'h2CF4, {16'h0000, r[15:0]});
        for (logic [7:0] c = 8'hD1; c < 8'hD7; c++) u_host.issue(c, 8'hB0);
        u_host.issue(8'hD9, 8'hB0);
        rd(12'h004, r);
        chk("health_off", 32'h0, {31'h0, r[4]});
        u_host.issue(8'hD8, 8'hB0);
        rd(12'h004, r);
        chk("health_on", 32'h1, {31'h0, r[4]});
    endtask
    task automatic t_cmds();
        logic [31:0] r;
        logic [15:0] c [4] = '{16'h0003, 16'h0004, 16'h0005, 16'h0007};
        logic [7:0] v [4] = '{8'h82, 8'h66, 8'h02, 8'hCC};
        logic [1:0] e [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
        for (int i = 0; i < 4; i++) begin
            wr(12'h02C, {16'h0000, c[i]});
            rd(12'h004, r);
            chk("sct_abort", {31'h0, i == 3}, {31'h0, r[1]});
        end
        chk("feat_rst", 32'h3, {30'h0, wcache_en_q, revert_en_q});
        for (int i = 0; i < 4; i++) begin
            u_host.issue(v[i], 8'hEF);
            @(posedge ref_clk);
            chk("setfeat", {30'h0, e[i]}, {30'h0, wcache_en_q, revert_en_q});
        end
        wr(12'hFFC, 32'hFFFF_FFFF);
        rd(12'hFFC, r);
        chk("unmapped", 32'h0, r);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_cmds();
        t_identify();
        t_health();
        t_status();
        close_out();
    end
    // Whole run is near 4k cycles; this limit leaves ample margin
    initial begin
        #250000;
        miscompares++;
        close_out();
    end
endmodule // smart_identify_responder_bench
`default_nettype wire
